// ===== tsr_pkg.sv
// Purpose: shared constants and types for the temperature sensor readout block
// Assumes: 50 MHz system clock
// Notes:   all timing counts derive from times in their own units
package tsr_pkg;

  // ********************************************************
  // clock and timing
  // ********************************************************
  localparam int unsigned CLK_HZ           = 50000000;     // system clock rate
  localparam int unsigned SLOW_PERIOD_MS   = 8000;         // low-power variant interval, 8 s
  localparam int unsigned FAST_PERIOD_MS   = 500;          // fast variant interval, 0.5 s
  localparam int unsigned CONV_TIME_MS     = 250;          // conversion duration, typical
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned SLOW_PERIOD_CYC  = SLOW_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned FAST_PERIOD_CYC  = FAST_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned CONV_TIME_CYC    = CONV_TIME_MS * CYC_PER_MS;

  // ********************************************************
  // data word layout
  // ********************************************************
  localparam int unsigned WORD_BITS        = 16;           // bits per read
  localparam int unsigned TEMP_BITS        = 13;           // sign plus 12 magnitude bits
  localparam int unsigned TEMP_LSB_POS     = 3;            // temperature sits in bits 15..3
  localparam int unsigned PRESENT_BIT_POS  = 2;            // always-low presence bit
  localparam logic [12:0] TEMP_RESET       = 13'h0000;     // 0 degrees after reset
  localparam logic [4:0]  DRIVEN_BITS      = 5'h0E;        // bits 15..2 are driven: 14 periods
  localparam int unsigned CNT_W            = 32;           // width of interval counters

  // conversion sequencer states
  typedef enum logic [2:0] {
    TSR_CONVERT = 3'b001,
    TSR_WAIT    = 3'b010,
    TSR_IDLE    = 3'b100
  } tsr_state_t;

endpackage

// ===== tsr_buf_if.sv
// Purpose: valid/ready channel carrying conversion results
// Assumes: one clock domain
// Notes:   data is a 13-bit temperature word
`timescale 1ns/10ps
`default_nettype none
interface tsr_buf_if;
  logic        valid;   // word offered
  logic        ready;   // word accepted
  logic [12:0] data;    // temperature word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== tsr_buf2.sv
// Purpose: two-entry buffer between converter and result latch
// Assumes: one clock domain
// Notes:   full and empty are exact; a stalled drain fills it
`timescale 1ns/10ps
`default_nettype none
module tsr_buf2 (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // channels
  tsr_buf_if.snk    in_ch,
  tsr_buf_if.src    out_ch
);
  logic [12:0] mem_q [2];   // storage entries
  logic        wr_q;        // write pointer
  logic        rd_q;        // read pointer
  logic [1:0]  cnt_q;       // occupancy
  logic        push;
  logic        pop;

  assign push         = in_ch.valid && in_ch.ready;
  assign pop          = out_ch.valid && out_ch.ready;
  assign in_ch.ready  = (cnt_q != 2'h2);
  assign out_ch.valid = (cnt_q != 2'h0);
  assign out_ch.data  = mem_q[rd_q];

  // pointers and occupancy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= tsr_pkg::TEMP_RESET;
      mem_q[1] <= tsr_pkg::TEMP_RESET;
    end else if (push) begin
      mem_q[wr_q] <= in_ch.data;
    end
  end
endmodule
`default_nettype wire

// ===== tsr_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to clock
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module tsr_sync #(
  parameter logic RST_VAL = 1'b0  // level both stages hold in reset: the pin's idle level
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // data
  input  wire logic din,
  output var  logic dout
);
  logic meta_q;   // first stage

  // two stages; reset to the idle level so no false edge follows reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== tsr_top.sv
// Purpose: conversion sequencing and serial readout of a temperature sensor
// Assumes: host drives cs_n and sck; temperature sample arrives as a word
// Notes:   serial output is two signals: data, enable, no tri-state here
`timescale 1ns/10ps
`default_nettype none
module tsr_top #(
  parameter int unsigned SLOW_CYC = tsr_pkg::SLOW_PERIOD_CYC,  // slow interval in cycles
  parameter int unsigned FAST_CYC = tsr_pkg::FAST_PERIOD_CYC,  // fast interval in cycles
  parameter int unsigned CONV_CYC = tsr_pkg::CONV_TIME_CYC     // conversion time in cycles
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // variant strap: high selects the fast interval
  input  wire logic        fast_variant,
  // analog front end sample, two's complement 0.0625 degree units
  input  wire logic [12:0] sense_temp,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sck,
  output var  logic        so_out,
  output var  logic        so_oe,
  // status
  output var  logic        converting
);

  // ********************************************************
  // pin synchronisation
  // ********************************************************
  logic cs_n_s;    // synchronised chip select
  logic sck_s;     // synchronised serial clock
  logic cs_n_q;    // previous chip select
  logic sck_q;     // previous serial clock
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic fast_s;    // synchronised variant strap

  // chip select idles high: reset high so no false fall appears
  tsr_sync #(
    .RST_VAL (1'b1)
  ) u_cs (
    .clock   (clock),
    .rst_n   (rst_n),
    .din     (cs_n),
    .dout    (cs_n_s)
  );

  // serial clock idles low
  tsr_sync #(
    .RST_VAL (1'b0)
  ) u_sck (
    .clock   (clock),
    .rst_n   (rst_n),
    .din     (sck),
    .dout    (sck_s)
  );

  // variant strap is a pin as well
  tsr_sync #(
    .RST_VAL (1'b0)
  ) u_var (
    .clock   (clock),
    .rst_n   (rst_n),
    .din     (fast_variant),
    .dout    (fast_s)
  );

  // edge history; cs treated high after reset so a low pin gives a fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      sck_q  <= 1'b0;
    end else begin
      cs_n_q <= cs_n_s;
      sck_q  <= sck_s;
    end
  end

  assign cs_fall  = cs_n_q && !cs_n_s;
  assign cs_rise  = !cs_n_q && cs_n_s;
  assign sck_fall = sck_q && !sck_s;

  // ********************************************************
  // conversion sequencer
  // ********************************************************
  tsr_pkg::tsr_state_t state_q;     // sequencer state
  tsr_pkg::tsr_state_t state_d;
  logic [31:0]         tmr_q;       // cycles since last conversion start
  logic [31:0]         period;      // chosen interval
  logic                conv_done;   // conversion finishes this cycle

  assign period     = fast_s ? 32'(FAST_CYC) : 32'(SLOW_CYC);
  assign conv_done  = (state_q == tsr_pkg::TSR_CONVERT) && (tmr_q == 32'(CONV_CYC) - 32'h1);
  assign converting = (state_q == tsr_pkg::TSR_CONVERT);

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      tsr_pkg::TSR_CONVERT: begin
        if (conv_done) begin
          state_d = tsr_pkg::TSR_WAIT;
        end
      end
      tsr_pkg::TSR_WAIT: begin
        if (tmr_q >= period - 32'h1) begin
          state_d = tsr_pkg::TSR_CONVERT;
        end
      end
      tsr_pkg::TSR_IDLE: begin
        state_d = tsr_pkg::TSR_IDLE;
      end
      default: begin
        state_d = tsr_pkg::TSR_CONVERT;
      end
    endcase
    if (cs_fall) begin
      state_d = tsr_pkg::TSR_IDLE;
    end else if (cs_rise) begin
      state_d = tsr_pkg::TSR_CONVERT;
    end
  end

  // state register; starts converting out of reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tsr_pkg::TSR_CONVERT;
    end else begin
      state_q <= state_d;
    end
  end

  // interval timer, restarted with every conversion start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= 32'h0;
    end else if (state_d == tsr_pkg::TSR_CONVERT && state_q != tsr_pkg::TSR_CONVERT) begin
      tmr_q <= 32'h0;
    end else if (state_q == tsr_pkg::TSR_WAIT && state_d == tsr_pkg::TSR_CONVERT) begin
      tmr_q <= 32'h0;
    end else if (state_q != tsr_pkg::TSR_IDLE) begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  // ********************************************************
  // result buffer
  // ********************************************************
  tsr_buf_if conv_ch ();
  tsr_buf_if res_ch ();
  logic [12:0] result_q;   // latest finished result

  // converter offers the sample when a conversion completes
  assign conv_ch.valid = conv_done;
  assign conv_ch.data  = sense_temp;
  assign res_ch.ready  = 1'b1;

  tsr_buf2 u_buf (
    .clock  (clock),
    .rst_n  (rst_n),
    .in_ch  (conv_ch),
    .out_ch (res_ch)
  );

  // result register; clears to zero degrees
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= tsr_pkg::TEMP_RESET;
    end else if (res_ch.valid) begin
      // two's complement word stored as is
      result_q <= res_ch.data;
    end
  end

  // ********************************************************
  // serial shifter
  // ********************************************************
  logic [15:0] shreg_q;   // output shift register
  logic [4:0]  bit_q;     // bit periods already shifted
  logic        act_q;     // cs low period active

  // shift register load and shift
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shreg_q <= 16'h0000;
    end else if (cs_fall) begin
      shreg_q <= {result_q, 3'h0};
    end else if (act_q && sck_fall) begin
      shreg_q <= {shreg_q[14:0], 1'b0};
    end
  end

  // bit counter and active flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 5'h00;
      act_q <= 1'b0;
    end else if (cs_fall) begin
      bit_q <= 5'h00;
      act_q <= 1'b1;
    end else if (cs_rise || cs_n_s) begin
      bit_q <= 5'h00;
      act_q <= 1'b0;
    end else if (act_q && sck_fall && bit_q != 5'h10) begin
      bit_q <= bit_q + 5'h01;
    end
  end

  // output pins from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else if (cs_fall) begin
      // sign bit appears right after cs fall
      so_out <= result_q[12];
      so_oe  <= 1'b1;
    end else if (!act_q || cs_n_s) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else if (sck_fall) begin
      so_out <= shreg_q[14];
      so_oe  <= (bit_q + 5'h01) < tsr_pkg::DRIVEN_BITS;
    end
  end

endmodule
`default_nettype wire

// ===== tsr_top_sva.sv
// Purpose: pin-level property checks for the readout block
// Assumes: sck phases of at least four clocks
// Notes:   pins are raw, so each check allows a short settle
`timescale 1ns/10ps
`default_nettype none
module tsr_top_chk #(
  parameter int unsigned SLOW_CYC = 400,  // slow interval
  parameter int unsigned FAST_CYC = 100,  // fast interval
  parameter int unsigned CONV_CYC = 20    // conversion time
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // pins
  input wire logic        fast_variant,
  input wire logic [12:0] sense_temp,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        so_out,
  input wire logic        so_oe,
  input wire logic        converting
);
  // ****************
  // helper counters
  // ****************
  int unsigned falls_q;  // sck falls in this frame
  int unsigned gap_q;    // cycles since a conversion start
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // sck falls while selected
  always_ff @(posedge clock) begin
    if (!rst_n || cs_n) falls_q <= 0;
    else if ($fell(sck)) falls_q <= falls_q + 1;
  end
  // interval since the last start, cleared by a read or a variant change
  always_ff @(posedge clock) begin
    if (!rst_n || !cs_n || $rose(converting) || $changed(fast_variant)) gap_q <= 0;
    else gap_q <= gap_q + 1;
  end
  // ****************
  // properties
  // ****************
  property p_cs_quiet; cs_n [*6] |-> !so_oe; endproperty
  property p_rise_off; $rose(cs_n) |-> ##[1:6] (!so_oe && converting); endproperty
  property p_idle; (!cs_n) [*6] |-> !converting; endproperty
  property p_interval; gap_q <= (fast_variant ? FAST_CYC : SLOW_CYC) + 8; endproperty
  property p_hold; (!cs_n && $rose(sck)) |-> ##1 ($stable(so_out) && $stable(so_oe)) [*4]; endproperty
  property p_d2; (falls_q == 13) [*6] |-> so_oe && !so_out; endproperty
  property p_tail; (falls_q >= 14) [*6] |-> !so_oe; endproperty
  property p_driven; (!cs_n && falls_q < 14) [*6] |-> so_oe; endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("output driven while deselected");
  a_rise_off: assert property (p_rise_off) else $error("no restart after select rise");
  a_idle: assert property (p_idle) else $error("converting while selected");
  a_interval: assert property (p_interval) else $error("conversion interval too long");
  a_hold: assert property (p_hold) else $error("output moved without sck fall");
  a_d2: assert property (p_d2) else $error("presence bit not low");
  a_tail: assert property (p_tail) else $error("trailing bits driven");
  a_driven: assert property (p_driven) else $error("word bit not driven");
  c_read: cover property ($fell(cs_n));
  c_full: cover property (falls_q == 16);
  c_auto: cover property ($rose(converting) && cs_n);
endmodule
`default_nettype wire

// ===== tsr_host.sv
// Purpose: serial master model reading the sensor word
// Assumes: sck cycle of 160 ns, idle low between frames
// Notes:   data is sampled at the end of each high phase
`timescale 1ns/10ps
`default_nettype none
module tsr_host #(
  parameter int HALF = 4  // sck half period in clocks
) (
  // clock
  input wire logic clock,
  // pins
  input wire logic so_out,
  input wire logic so_oe,
  output var logic cs_n,
  output var logic sck
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  // one frame of nbits clocks, then deselected for hold clocks
  task automatic xfer(input int nbits, input int hold, output logic [15:0] data, output int drv);
    data = 16'h0000;
    drv = 0;
    @(posedge clock) cs_n <= 1'b0;
    repeat (2 * HALF) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      sck <= 1'b1;
      repeat (HALF) @(posedge clock);
      // a released line has no pull: read the inverse so a missing drive shows
      if (i < 16) data[15 - i] = so_oe ? so_out : ~so_out;
      if (so_oe === 1'b1) drv++;
      sck <= 1'b0;
      repeat (HALF) @(posedge clock);
    end
    cs_n <= 1'b1;
    repeat (hold) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: self-checking bench for the readout block
// Assumes: shortened interval parameters
// Notes:   random temperatures from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int unsigned SLOW = 400;
  localparam int unsigned FAST = 100;
  localparam int unsigned CONV = 20;
  localparam int HOLD = CONV + 10;  // one whole conversion plus 10 cycles
  logic        clock, rst_n, fast_variant, cs_n, sck, so_out, so_oe, converting;
  logic [12:0] sense_temp, t;
  logic [15:0] word;
  int          drv, n, failures, cmp_count;
  logic [12:0] temps [4] = '{13'h0190, 13'h1E70, 13'h1FFF, 13'h0960};
  tsr_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .CONV_CYC(CONV)) dut_u (.clock(clock), .rst_n(rst_n),
    .fast_variant(fast_variant), .sense_temp(sense_temp), .cs_n(cs_n), .sck(sck), .so_out(so_out),
    .so_oe(so_oe), .converting(converting));
  tsr_host host_u (.clock(clock), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck));
  function automatic logic [15:0] exp_word(logic [12:0] v);
    return {v, 3'b000};
  endfunction
  task automatic complete_run;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_count(string nm, int e, int g);
    chk_word(nm, 16'(e), 16'(g));
  endtask
  // bounded wait for the converting level, sampled off the edge
  task automatic wait_conv(logic lvl);
    for (int k = 0; converting !== lvl; k++) begin
      @(negedge clock);
      if (k > 1000) begin
        failures++;
        complete_run();
      end
    end
  endtask
  task automatic read_check(logic [12:0] v, int nbits);
    host_u.xfer(nbits, HOLD, word, drv);
    chk_word("word", exp_word(v), word & 16'hFFFC);
    chk_count("driven bits", 14, drv);
  endtask
  // cycles from one conversion start to the next
  task automatic measure(output int p);
    wait_conv(1'b0);
    wait_conv(1'b1);
    p = 0;
    while (converting === 1'b1 && p < 2000) begin
      @(negedge clock);
      p++;
    end
    while (converting !== 1'b1 && p < 2000) begin
      @(negedge clock);
      p++;
    end
    if (p >= 2000) begin
      failures++;
      complete_run();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    n = $urandom(16);
    rst_n = 1'b0;
    fast_variant = 1'b1;
    sense_temp = 13'h0190;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock);
    chk_word("oe in reset", 16'h0000, {15'h0000, so_oe});
    rst_n <= 1'b1;
    read_check(13'h0000, 16);
    for (int i = 0; i < 8; i++) begin
      t = (i < 4) ? temps[i] : 13'($urandom);
      @(posedge clock) sense_temp <= t;
      wait_conv(1'b1);
      wait_conv(1'b0);
      read_check(t, 16);
    end
    @(posedge clock) sense_temp <= ~t;
    wait_conv(1'b1);
    read_check(t, 16);
    host_u.xfer(5, HOLD, word, drv);
    chk_word("partial", exp_word(~t) & 16'hF800, word & 16'hF800);
    read_check(~t, 18);
    measure(n);
    chk_count("fast interval", FAST, n);
    @(posedge clock) fast_variant <= 1'b0;
    measure(n);
    measure(n);
    chk_count("slow interval", SLOW, n);
    @(posedge clock) rst_n <= 1'b0;
    @(posedge clock) sense_temp <= 13'h0ABC;
    @(posedge clock) rst_n <= 1'b1;
    wait_conv(1'b0);
    read_check(13'h0ABC, 16);
    complete_run();
  end
endmodule
bind tsr_top tsr_top_chk #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC), .CONV_CYC(CONV_CYC)) chk_u (
  .clock(clock), .rst_n(rst_n), .fast_variant(fast_variant), .sense_temp(sense_temp), .cs_n(cs_n),
  .sck(sck), .so_out(so_out), .so_oe(so_oe), .converting(converting));
`default_nettype wire
